// *** inc/lcgis_pkg.sv ***
// constants for the logic cell gate input selection stage
// Overview of operation
// - true data inputs gated into gate 1
// - inverted data inputs gated into gate 1
// - true data inputs gated into gate 2
// - inverted data inputs gated into gate 2
// - odd bits gate true inputs into gate 3
// - even bits gate inverted inputs into gate 3
// - selection registers read/write, no reset clearing
// - polarity bit inverts gate output
// - six-bit source field per data input
`default_nettype none
package lcgis_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int NUM_REGS = 8;
	localparam int NUM_DATA = 4;
	localparam int NUM_GATES = 3;
	localparam int SRC_SEL_W = 6;
	localparam int NUM_SRC = 64;
	// register map
	localparam logic [ADDR_W-1:0] OFS_DATA1_SRC = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_DATA2_SRC = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_DATA3_SRC = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_DATA4_SRC = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_GATE1_SEL = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_GATE2_SEL = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_GATE3_SEL = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_POLARITY = 4'h7;
	localparam logic [ADDR_W-1:0] OFS_LAST = 4'h7;
	// source select registers keep only the low six bits
	localparam logic [DATA_W-1:0] SRC_SEL_MASK = 8'h3F;
	localparam logic [DATA_W-1:0] FULL_MASK = 8'hFF;
	// each data input owns a pair of selection bits: true above inverted
	localparam int SEL_TRUE_OFS = 1;
	localparam int SEL_INV_OFS = 0;
	localparam int SEL_BITS_PER_INPUT = 2;
	// polarity register: gate N invert control sits at bit N
	localparam int POL_GATE1_BIT = 1;
	localparam int POL_GATE2_BIT = 2;
	localparam int POL_GATE3_BIT = 3;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
endpackage
`default_nettype wire

// *** design/lcgis_regmem.sv ***
// small register memory with registered read data and a flat view of all words
`timescale 1ns/1ps
`default_nettype none
module lcgis_regmem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read port
	input wire logic rd_en,
	input wire logic rd_hit,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data_ff,
	// all words side by side, word 0 lowest
	output logic [DEPTH*WIDTH-1:0] words
);
	logic [WIDTH-1:0] mem_ff [DEPTH];

	// contents are not reset: they keep their value across reset
	always_ff @(posedge clock)
	begin
		if (wr_en)
			mem_ff[wr_addr] <= wr_data;
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n || !rd_en || !rd_hit)
			rd_data_ff <= '0;
		else
			rd_data_ff <= mem_ff[rd_addr];
	end

	always_comb
	begin
		for (int i = 0; i < DEPTH; i++)
			words[i*WIDTH +: WIDTH] = mem_ff[i];
	end
endmodule
`default_nettype wire

// *** design/lcgis_top.sv ***
// gate input selection stage of a configurable logic cell
`timescale 1ns/1ps
`default_nettype none
module lcgis_top #(
	parameter int NSRC = lcgis_pkg::NUM_SRC
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire logic [lcgis_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [lcgis_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [lcgis_pkg::DATA_W-1:0] reg_rdata,
	// candidate sources for the four data inputs
	input wire logic [NSRC-1:0] src_bus,
	// selected data inputs and gate results toward the logic function
	output logic [lcgis_pkg::NUM_DATA-1:0] data_sel_ff,
	output logic [lcgis_pkg::NUM_GATES:1] gate_out_ff
);
	import lcgis_pkg::*;

	localparam int MEM_AW = 3;

	function automatic logic gate_or(input logic [DATA_W-1:0] sel, input logic [NUM_DATA-1:0] d);
		logic acc;
		acc = 1'b0;
		for (int k = 0; k < NUM_DATA; k++)
		begin
			acc = acc | (sel[k*SEL_BITS_PER_INPUT + SEL_TRUE_OFS] & d[k]);
			acc = acc | (sel[k*SEL_BITS_PER_INPUT + SEL_INV_OFS] & ~d[k]);
		end
		return acc;
	endfunction

	function automatic logic [DATA_W-1:0] wmask(input logic [ADDR_W-1:0] a);
		return (a <= OFS_DATA4_SRC) ? SRC_SEL_MASK : FULL_MASK;
	endfunction

	function automatic logic pick_src(input logic [DATA_W-1:0] r, input logic [NSRC-1:0] bus);
		return bus[r[SRC_SEL_W-1:0]];
	endfunction

	wire logic addr_hit = (reg_addr <= OFS_LAST);
	wire logic [DATA_W-1:0] wdata_masked = reg_wdata & wmask(reg_addr);
	wire logic [NUM_REGS*DATA_W-1:0] words;
	wire logic [DATA_W-1:0] mem_rdata;

	lcgis_regmem #(
		.WIDTH(DATA_W),
		.DEPTH(NUM_REGS),
		.AW(MEM_AW)
	) u_mem (
		.clock(clock),
		.reset_n(reset_n),
		.wr_en(reg_wr && addr_hit),
		.wr_addr(reg_addr[MEM_AW-1:0]),
		.wr_data(wdata_masked),
		.rd_en(reg_rd),
		.rd_hit(addr_hit),
		.rd_addr(reg_addr[MEM_AW-1:0]),
		.rd_data_ff(mem_rdata),
		.words(words)
	);
	assign reg_rdata = mem_rdata;

	wire logic [DATA_W-1:0] src_reg0 = words[int'(OFS_DATA1_SRC)*DATA_W +: DATA_W];
	wire logic [DATA_W-1:0] src_reg1 = words[int'(OFS_DATA2_SRC)*DATA_W +: DATA_W];
	wire logic [DATA_W-1:0] src_reg2 = words[int'(OFS_DATA3_SRC)*DATA_W +: DATA_W];
	wire logic [DATA_W-1:0] src_reg3 = words[int'(OFS_DATA4_SRC)*DATA_W +: DATA_W];
	wire logic [DATA_W-1:0] gate1_input_select = words[int'(OFS_GATE1_SEL)*DATA_W +: DATA_W];
	wire logic [DATA_W-1:0] gate2_input_select = words[int'(OFS_GATE2_SEL)*DATA_W +: DATA_W];
	wire logic [DATA_W-1:0] gate3_input_select = words[int'(OFS_GATE3_SEL)*DATA_W +: DATA_W];
	wire logic [DATA_W-1:0] polarity_reg = words[int'(OFS_POLARITY)*DATA_W +: DATA_W];

	wire logic gate1_output_invert = polarity_reg[POL_GATE1_BIT];
	wire logic gate2_output_invert = polarity_reg[POL_GATE2_BIT];
	wire logic gate3_output_invert = polarity_reg[POL_GATE3_BIT];

	wire logic [NUM_DATA-1:0] d_now = {pick_src(src_reg3, src_bus), pick_src(src_reg2, src_bus),
		pick_src(src_reg1, src_bus), pick_src(src_reg0, src_bus)};

	wire logic g1_raw = gate_or(gate1_input_select, d_now);
	wire logic g2_raw = gate_or(gate2_input_select, d_now);
	wire logic g3_raw = gate_or(gate3_input_select, d_now);

	wire logic [NUM_GATES:1] nxt_gate_out = {g3_raw ^ gate3_output_invert,
		g2_raw ^ gate2_output_invert, g1_raw ^ gate1_output_invert};

	// outputs held low in reset so the logic function never sees unknowns then
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			data_sel_ff <= '0;
			gate_out_ff <= '0;
		end
		else
		begin
			data_sel_ff <= d_now;
			gate_out_ff <= nxt_gate_out;
		end
	end

	// helpers for the checks below: the first edge after reset still shows
	// reset values, and data input 1 is unknown until its source is written
	logic live_ff;
	logic src0_set_ff;

	always_ff @(posedge clock)
	begin
		live_ff <= reset_n;
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
			src0_set_ff <= 1'h0;
		else if (reg_wr && reg_addr == OFS_DATA1_SRC)
			src0_set_ff <= 1'h1;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n || !live_ff);

	property p_g1_true;
		gate1_input_select == 8'h80 && !gate1_output_invert |=> gate_out_ff[1] == $past(d_now[3]);
	endproperty
	a_g1_true: assert property (p_g1_true) else $error("gate 1 true input 4 wrong");

	property p_g1_inv;
		gate1_input_select == 8'h01 && !gate1_output_invert |=> gate_out_ff[1] == !$past(d_now[0]);
	endproperty
	a_g1_inv: assert property (p_g1_inv) else $error("gate 1 inverted input 1 wrong");

	property p_g2_true;
		gate2_input_select == 8'h20 && !gate2_output_invert |=> gate_out_ff[2] == $past(d_now[2]);
	endproperty
	a_g2_true: assert property (p_g2_true) else $error("gate 2 true input 3 wrong");

	property p_g2_inv;
		gate2_input_select == 8'h04 && !gate2_output_invert |=> gate_out_ff[2] == !$past(d_now[1]);
	endproperty
	a_g2_inv: assert property (p_g2_inv) else $error("gate 2 inverted input 2 wrong");

	property p_g3_true;
		gate3_input_select == 8'h0A && !gate3_output_invert
			|=> gate_out_ff[3] == ($past(d_now[1]) | $past(d_now[0]));
	endproperty
	a_g3_true: assert property (p_g3_true) else $error("gate 3 true inputs 1,2 wrong");

	property p_g3_inv;
		gate3_input_select == 8'h40 && !gate3_output_invert |=> gate_out_ff[3] == !$past(d_now[3]);
	endproperty
	a_g3_inv: assert property (p_g3_inv) else $error("gate 3 inverted input 4 wrong");

	property p_readback;
		(reg_wr && addr_hit) ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr))
			|=> reg_rdata == ($past(reg_wdata, 2) & wmask($past(reg_addr, 2)));
	endproperty
	a_readback: assert property (p_readback) else $error("register readback mismatch");

	property p_pol;
		gate1_input_select == 8'h00 |=> gate_out_ff[1] == $past(gate1_output_invert);
	endproperty
	a_pol: assert property (p_pol) else $error("gate 1 polarity wrong");

	property p_src;
		src0_set_ff |=> data_sel_ff[0] == $past(src_bus[src_reg0[SRC_SEL_W-1:0]]);
	endproperty
	a_src: assert property (p_src) else $error("data input 1 source wrong");

	property p_src_hi;
		reg_rd && reg_addr <= OFS_DATA4_SRC |=> reg_rdata[DATA_W-1:SRC_SEL_W] == 2'b00;
	endproperty
	a_src_hi: assert property (p_src_hi) else $error("source select upper bits not zero");

	property p_none;
		gate2_input_select == 8'h00 && !gate2_output_invert |=> !gate_out_ff[2];
	endproperty
	a_none: assert property (p_none) else $error("empty gate 2 not zero");

	property p_unmapped;
		reg_rd && !addr_hit |=> reg_rdata == RDATA_IDLE;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_rd_idle;
		!reg_rd |=> reg_rdata == RDATA_IDLE;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle outside read");

	property p_g2_d1_true;
		gate2_input_select == 8'h02 && !gate2_output_invert |=> gate_out_ff[2] == $past(d_now[0]);
	endproperty
	a_g2_d1_true: assert property (p_g2_d1_true) else $error("gate 2 true input 1 wrong");

	property p_g3_d2_inv;
		gate3_input_select == 8'h04 && !gate3_output_invert |=> gate_out_ff[3] == !$past(d_now[1]);
	endproperty
	a_g3_d2_inv: assert property (p_g3_d2_inv) else $error("gate 3 inverted input 2 wrong");

	property p_pol3;
		gate3_input_select == 8'h00 |=> gate_out_ff[3] == $past(gate3_output_invert);
	endproperty
	a_pol3: assert property (p_pol3) else $error("gate 3 polarity wrong");

	property p_g1_both;
		gate1_input_select == 8'hC0 |=> gate_out_ff[1] == !$past(gate1_output_invert);
	endproperty
	a_g1_both: assert property (p_g1_both) else $error("gate 1 both forms not high");

	c_g1_both: cover property (gate1_input_select == 8'hC0 ##1 gate_out_ff[1]);
	c_src_set: cover property (src0_set_ff ##1 data_sel_ff[0]);
	c_g3_inverted: cover property (gate3_output_invert && gate3_input_select != 8'h00);
	c_readback: cover property (reg_wr ##1 reg_rd);
	c_g2_high: cover property (gate2_input_select == 8'h55 ##1 gate_out_ff[2]);
endmodule
`default_nettype wire

// *** dv/lcgis_top_test.sv ***
// self-checking bench for the gate input selection stage
`timescale 1ns/1ps
`default_nettype none
module lcgis_top_test;
	import lcgis_pkg::*;
	logic clock;
	logic reset_n;
	logic reg_wr;
	logic reg_rd;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic [DATA_W-1:0] reg_rdata;
	logic [NUM_SRC-1:0] src_bus;
	logic [NUM_DATA-1:0] data_sel_ff;
	logic [NUM_GATES:1] gate_out_ff;
	logic [7:0] regs_m [8];
	int mismatches;
	int comparisons;
	lcgis_top uut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.src_bus(src_bus), .data_sel_ff(data_sel_ff), .gate_out_ff(gate_out_ff));
	initial
	begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// write strobe stays up for a following write; rd and step lower it
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		reg_rd <= 1'h0;
		@(posedge clock);
		if (a <= OFS_LAST)
			regs_m[a[2:0]] = (a < OFS_GATE1_SEL) ? (d & SRC_SEL_MASK) : d;
	endtask
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'h1;
		reg_wr <= 1'h0;
		@(posedge clock);
		reg_rd <= 1'h0;
		@(negedge clock);
		chk(reg_rdata, (a <= OFS_LAST) ? regs_m[a[2:0]] : 8'h00);
		@(posedge clock);
	endtask
	function automatic logic [6:0] expect_out(input logic [63:0] v);
		logic [3:0] d;
		logic [2:0] g;
		g = 3'h0;
		for (int k = 0; k < 4; k++)
			d[k] = v[regs_m[k][5:0]];
		for (int n = 1; n <= 3; n++)
			for (int k = 0; k < 4; k++)
				g[n-1] |= (regs_m[3+n][2*k+1] & d[k]) | (regs_m[3+n][2*k] & ~d[k]);
		return {d, g ^ regs_m[OFS_POLARITY][3:1]};
	endfunction
	task automatic step(input logic [63:0] v);
		logic [6:0] e;
		e = expect_out(v);
		src_bus <= v;
		reg_wr <= 1'h0;
		@(posedge clock);
		@(negedge clock);
		chk({4'h0, data_sel_ff}, {4'h0, e[6:3]});
		chk({5'h0, gate_out_ff}, {5'h0, e[2:0]});
		@(posedge clock);
	endtask
	initial
	begin
		#500000;
		mismatches++;
		test_done();
	end
	initial
	begin
		reset_n = 1'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		src_bus = 64'h0;
		mismatches = 0;
		comparisons = 0;
		void'($urandom(32'h9B6BA278));
		repeat (20) @(posedge clock);
		reset_n <= 1'h1;
		for (int a = 0; a < 16; a++)
		begin
			wr(4'(a), 8'($urandom));
			rd(4'(a));
		end
		$display("test registers done");
		for (int g = 1; g <= 3; g++)
			for (int b = 0; b < 9; b++)
			begin
				wr(4'(3 + g), (b < 8) ? 8'(1 << b) : 8'h00);
				wr(OFS_POLARITY, 8'($urandom));
				repeat (4) step({$urandom, $urandom});
			end
		$display("test walking selects done");
		// a two-input gate, both forms of one input, empty gate with plain polarity
		wr(OFS_POLARITY, 8'h00);
		wr(OFS_GATE1_SEL, 8'hC0);
		wr(OFS_GATE2_SEL, 8'h00);
		wr(OFS_GATE3_SEL, 8'h0A);
		repeat (4) step({$urandom, $urandom});
		wr(OFS_GATE2_SEL, 8'h55);
		repeat (4) step({$urandom, $urandom});
		$display("test corner cases done");
		repeat (300)
		begin
			if ($urandom_range(3) == 0)
				wr(4'($urandom_range(7)), 8'($urandom));
			step({$urandom, $urandom});
		end
		$display("test random traffic done");
		reset_n <= 1'h0;
		@(posedge clock);
		@(negedge clock);
		chk({5'h0, gate_out_ff}, 8'h00);
		chk({4'h0, data_sel_ff}, 8'h00);
		chk(reg_rdata, 8'h00);
		@(posedge clock);
		reset_n <= 1'h1;
		@(posedge clock);
		for (int a = 0; a < 8; a++)
			rd(4'(a));
		step({$urandom, $urandom});
		$display("test reset retention done");
		test_done();
	end
endmodule
`default_nettype wire
